// file: serial_engine_model.sv
// far-side model of the shift engine: delivers received bytes and drains the transmit side
`timescale 1ns/1ns
module serial_engine_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [7:0] n_push,
    input  wire logic       drain,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_avail,
    output logic            tx_pop,
    output logic            rx_push,
    output logic      [7:0] rx_byte,
    output logic            sending,
    output logic            got,
    output logic      [7:0] got_byte
);
    logic [7:0] cnt_r;
    logic [7:0] seq_r;
    logic       pace_r;
    // take a byte only when offered; slow mode waits every other cycle
    assign tx_pop  = drain && tx_avail && (!slow || pace_r);
    assign sending = drain;
    // one received byte every other cycle while a burst is owed
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r   <= 8'h00;
            seq_r   <= 8'h00;
            pace_r  <= 1'b0;
            rx_push <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            pace_r  <= ~pace_r;
            rx_push <= 1'b0;
            rx_byte <= ~rx_byte;  // idle data line inverts every cycle, so it shows the last byte every other cycle
            if (go) begin
                cnt_r <= n_push;
            end else if (cnt_r != 8'h00 && pace_r) begin
                cnt_r   <= cnt_r - 8'h01;
                seq_r   <= seq_r + 8'h01;
                rx_push <= 1'b1;
                rx_byte <= 8'hA0 + seq_r;
            end
        end
    end
    // report each taken byte one cycle later
    always_ff @(posedge clk) begin
        got      <= tx_pop;
        got_byte <= tx_byte;
    end
endmodule // serial_engine_model

// file: spi_byte_fifo.sv
// sixteen-entry byte fifo with flush, level and flags
`timescale 1ns/1ns
module spi_byte_fifo (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              flush,
    input  wire logic                              push,
    input  wire logic [spi_tail_pkg::DATA_W-1:0]   din,
    input  wire logic                              pop,
    output logic      [spi_tail_pkg::DATA_W-1:0]   head,
    output logic      [spi_tail_pkg::LVL_W-1:0]    level,
    output logic                                   full,
    output logic                                   empty
);
    logic [spi_tail_pkg::DATA_W-1:0]  mem [spi_tail_pkg::FIFO_DEPTH];
    logic [spi_tail_pkg::FIFO_AW-1:0] wptr_r;
    logic [spi_tail_pkg::FIFO_AW-1:0] rptr_r;
    logic [spi_tail_pkg::LVL_W-1:0]   cnt_r;
    logic                             do_push;
    logic                             do_pop;

    // flags and accepted moves; a push when full or pop when empty is dropped
    assign full    = (cnt_r == 5'(spi_tail_pkg::FIFO_DEPTH));
    assign empty   = (cnt_r == 5'h00);
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign head    = mem[rptr_r];
    assign level   = cnt_r;

    // storage
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wptr_r] <= din;
        end
    end

    // pointers and count, flush wins over any move
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wptr_r <= 4'h0;
            rptr_r <= 4'h0;
            cnt_r  <= 5'h00;
        end else begin
            if (do_push) begin
                wptr_r <= wptr_r + 4'h1;
            end
            if (do_pop) begin
                rptr_r <= rptr_r + 4'h1;
            end
            cnt_r <= cnt_r + 5'(do_push) - 5'(do_pop);
        end
    end
endmodule // spi_byte_fifo

// file: spi_irq_dma_legacy_regs.sv
// interrupt routing, dma requests and legacy register view of the serial controller
`timescale 1ns/1ns
// Functional notes
// - writing one to clear bit 0 clears overrun flag and empties receive fifo
// - route select bit 1 gates auxiliary controller irq, bit 0 main cpu, reset 1
// - single requests always raised; burst requests added alongside
// - transmit request while tx enable, tx fifo not full and module enabled
// - transmit burst request when tx fifo has room for four words
// - receive request while rx enable, rx fifo not empty and module enabled
// - receive burst request when rx fifo holds at least four words
// - dropping dma enable or module enable drops the matching requests
// - four legacy registers operate the same controller as the primary set
// - legacy fifos are sixteen deep with thresholds fixed at four
// - legacy write needs low valid flag, low byte only; high valid reads zero
// - legacy status write one to bit 23 clears out-empty flag; bits 21..18 follow fifo state, all other bits ignored
// - legacy status shows out count 17:9, in count 8:0, bit 25 selected
// - legacy control bit 31 enable, 30 master, 29 falling edge primary
// - legacy phase bit 28 is the inverse of the primary phase bit
// - legacy bit 11 selects automatic chip select, else software slave select field
// - four-bit rate code picks one of sixteen rates; code zero still clocks
// - primary rate changes do not update the legacy rate field
// - legacy write and read enables read one; burst fields have no effect
// - legacy soft clear bit 0 clears pending interrupts and both fifos
// - legacy enables gate out-empty, out-level, in-full and in-data events
// - latched flags clear by writing one; fifo state flags follow their condition
module spi_irq_dma_legacy_regs (
    input  wire logic         MCLK,
    input  wire logic         RST,
    input  wire logic [31:0]  ADDR,
    input  wire logic [31:0]  WDATA,
    input  wire logic         WR,
    input  wire logic         RD,
    output logic      [31:0]  RDATA,
    input  wire logic         MOD_EN,
    input  wire logic [6:0]   IRQ_MASK,
    input  wire logic         SLAVE_SENDING,
    input  wire logic         EXT_SEL_PIN,
    input  wire logic         RX_TMO,
    input  wire logic         RX_PUSH,
    input  wire logic [7:0]   RX_BYTE,
    input  wire logic         TX_POP,
    output logic      [7:0]   TX_BYTE,
    output logic              TX_AVAIL,
    output logic              IRQ_MAIN,
    output logic              IRQ_AUX,
    output logic              TX_DMA_SREQ,
    output logic              TX_DMA_BREQ,
    output logic              RX_DMA_SREQ,
    output logic              RX_DMA_BREQ,
    output logic              CFG_EN,
    output logic              CFG_MASTER,
    output logic              CFG_CPOL,
    output logic              CFG_CPHA,
    output logic              CFG_CS_AUTO,
    output logic      [2:0]   CFG_SS,
    output logic      [3:0]   CFG_RATE
);
    logic [1:0]  cpu_sel_r;
    logic [1:0]  dma_ctl_r;
    logic [2:0]  burst_len_r;
    logic [2:0]  burst_gap_r;
    logic        ncpha_r;
    logic [24:0] lien_r;
    logic        ovr_r;
    logic        tmo_r;
    logic        oempty_r;
    logic        ext_s1_r;
    logic        ext_s2_r;
    logic [31:0] rdata_nxt;
    logic        wr_iclr;
    logic        wr_lstat;
    logic        wr_lctrl;
    logic        soft_clr;
    logic        rx_flush;
    logic        tx_flush;
    logic        tx_push;
    logic        rx_pop;
    logic        en;
    logic [7:0]  rx_head;
    logic [7:0]  tx_head;
    logic [4:0]  rx_lvl;
    logic [4:0]  tx_lvl;
    logic        rx_full;
    logic        rx_empty;
    logic        tx_full;
    logic        tx_empty;
    logic [6:0]  raw;
    logic [4:0]  lflags;
    logic [4:0]  lmask;
    logic        irq_any;

    // write decode
    assign wr_iclr  = WR && (ADDR == spi_tail_pkg::A_INT_CLR);
    assign wr_lstat = WR && (ADDR == spi_tail_pkg::A_LG_STAT);
    assign wr_lctrl = WR && (ADDR == spi_tail_pkg::A_LG_CTRL);
    assign soft_clr = wr_lctrl && WDATA[spi_tail_pkg::LC_SOFT];
    // fifo flushes, receive from either view, transmit from legacy only
    assign rx_flush = (wr_iclr && WDATA[spi_tail_pkg::CLR_OVR]) || soft_clr
                   || (wr_lctrl && WDATA[spi_tail_pkg::LC_IFLUSH]);
    assign tx_flush = soft_clr || (wr_lctrl && WDATA[spi_tail_pkg::LC_OFLUSH]);
    // legacy data port pushes only with the low valid flag, low byte kept
    assign tx_push  = WR && (ADDR == spi_tail_pkg::A_LG_DATA) && WDATA[spi_tail_pkg::LD_VALID0];
    assign rx_pop   = RD && (ADDR == spi_tail_pkg::A_LG_DATA);
    // module enable from primary control or legacy enable, same controller
    assign en       = MOD_EN || CFG_EN;

    // receive fifo, sixteen bytes
    spi_byte_fifo u_rx_fifo (
        .clk   (MCLK),
        .rst   (RST),
        .flush (rx_flush),
        .push  (RX_PUSH),
        .din   (RX_BYTE),
        .pop   (rx_pop),
        .head  (rx_head),
        .level (rx_lvl),
        .full  (rx_full),
        .empty (rx_empty)
    );

    // transmit fifo, sixteen bytes
    spi_byte_fifo u_tx_fifo (
        .clk   (MCLK),
        .rst   (RST),
        .flush (tx_flush),
        .push  (tx_push),
        .din   (WDATA[7:0]),
        .pop   (TX_POP),
        .head  (tx_head),
        .level (tx_lvl),
        .full  (tx_full),
        .empty (tx_empty)
    );

    // head byte toward the shift engine
    always_ff @(posedge MCLK) begin
        if (RST) begin
            TX_BYTE  <= 8'h00;
            TX_AVAIL <= 1'b0;
        end else begin
            TX_BYTE  <= tx_head;
            TX_AVAIL <= !tx_empty && !TX_POP && !tx_flush;
        end
    end

    // external select pin synchroniser
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end else begin
            ext_s1_r <= EXT_SEL_PIN;
            ext_s2_r <= ext_s1_r;
        end
    end

    // cpu route and dma control registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cpu_sel_r <= spi_tail_pkg::CPU_SEL_RST;
            dma_ctl_r <= spi_tail_pkg::DMA_CTL_RST;
        end else if (WR && ADDR == spi_tail_pkg::A_CPU_SEL) begin
            cpu_sel_r <= WDATA[1:0];
        end else if (WR && ADDR == spi_tail_pkg::A_DMA_CTL) begin
            dma_ctl_r <= WDATA[1:0];
        end
    end

    // legacy control; burst fields stored for read back only
    always_ff @(posedge MCLK) begin
        if (RST) begin
            CFG_EN      <= 1'b0;
            CFG_MASTER  <= 1'b0;
            CFG_CPOL    <= 1'b0;
            ncpha_r     <= 1'b0;
            CFG_CPHA    <= 1'b1;
            burst_len_r <= 3'h0;
            burst_gap_r <= 3'h0;
            CFG_CS_AUTO <= 1'b0;
            CFG_SS      <= 3'h0;
            CFG_RATE    <= 4'h0;
        end else if (wr_lctrl) begin
            CFG_EN      <= WDATA[spi_tail_pkg::LC_EN];
            CFG_MASTER  <= WDATA[spi_tail_pkg::LC_MS];
            CFG_CPOL    <= WDATA[spi_tail_pkg::LC_CPOL];
            ncpha_r     <= WDATA[spi_tail_pkg::LC_NCPHA];
            CFG_CPHA    <= !WDATA[spi_tail_pkg::LC_NCPHA];
            burst_len_r <= WDATA[27:25];
            burst_gap_r <= WDATA[24:22];
            CFG_CS_AUTO <= WDATA[spi_tail_pkg::LC_CSAUTO];
            CFG_SS      <= WDATA[10:8];
            CFG_RATE    <= WDATA[4:1];
        end
    end

    // legacy interrupt enable and watermark fields
    always_ff @(posedge MCLK) begin
        if (RST) begin
            lien_r <= 25'h0;
        end else if (WR && ADDR == spi_tail_pkg::A_LG_IEN) begin
            lien_r <= WDATA[24:0];
        end
    end

    // latched event flags, a set in the clearing cycle wins
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ovr_r    <= 1'b0;
            tmo_r    <= 1'b0;
            oempty_r <= 1'b0;
        end else begin
            ovr_r <= (RX_PUSH && rx_full) || (ovr_r && !soft_clr
                     && !(wr_iclr && WDATA[spi_tail_pkg::CLR_OVR]));
            tmo_r <= RX_TMO || (tmo_r && !soft_clr
                     && !(wr_iclr && WDATA[spi_tail_pkg::CLR_TMO]));
            oempty_r <= (SLAVE_SENDING && !CFG_MASTER && tx_empty)
                     || (oempty_r && !soft_clr
                     && !(wr_lstat && WDATA[spi_tail_pkg::LS_OEMPTY]));
        end
    end

    // raw primary states and legacy flags; fifo state ones follow the fifos
    assign raw    = {tx_empty, rx_full, !rx_empty, tx_lvl < spi_tail_pkg::FILL_FIX,
                     rx_lvl >= spi_tail_pkg::FILL_FIX, tmo_r, ovr_r};
    assign lflags = {oempty_r, tx_lvl < spi_tail_pkg::FILL_FIX, rx_full,
                     !rx_empty, rx_lvl >= spi_tail_pkg::FILL_FIX};
    assign lmask  = {lien_r[23], lien_r[21], lien_r[20], lien_r[19], lien_r[18]};
    assign irq_any = |(raw & IRQ_MASK) || |(lflags & lmask);

    // routed, registered processor interrupts
    always_ff @(posedge MCLK) begin
        if (RST) begin
            IRQ_MAIN <= 1'b0;
            IRQ_AUX  <= 1'b0;
        end else begin
            IRQ_MAIN <= irq_any && cpu_sel_r[spi_tail_pkg::SEL_MAIN];
            IRQ_AUX  <= irq_any && cpu_sel_r[spi_tail_pkg::SEL_AUX];
        end
    end

    // dma requests, single and burst side by side
    always_ff @(posedge MCLK) begin
        if (RST) begin
            TX_DMA_SREQ <= 1'b0;
            TX_DMA_BREQ <= 1'b0;
            RX_DMA_SREQ <= 1'b0;
            RX_DMA_BREQ <= 1'b0;
        end else begin
            TX_DMA_SREQ <= dma_ctl_r[spi_tail_pkg::DMA_TX] && en && !tx_full;
            TX_DMA_BREQ <= dma_ctl_r[spi_tail_pkg::DMA_TX] && en
                           && (tx_lvl <= spi_tail_pkg::TX_BURST_MAX);
            RX_DMA_SREQ <= dma_ctl_r[spi_tail_pkg::DMA_RX] && en && !rx_empty;
            RX_DMA_BREQ <= dma_ctl_r[spi_tail_pkg::DMA_RX] && en
                           && (rx_lvl >= spi_tail_pkg::FILL_FIX);
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        case (ADDR)
            spi_tail_pkg::A_CPU_SEL: rdata_nxt = {30'h0, cpu_sel_r};
            spi_tail_pkg::A_DMA_CTL: rdata_nxt = {30'h0, dma_ctl_r};
            spi_tail_pkg::A_LG_DATA: rdata_nxt = {14'h0, 1'b0, !rx_empty, 8'h00, rx_head};
            spi_tail_pkg::A_LG_STAT: rdata_nxt = {6'h00, ext_s2_r, tx_full, lflags[4],
                                      1'b0, lflags[3:0], 4'h0, tx_lvl, 4'h0, rx_lvl};
            spi_tail_pkg::A_LG_CTRL: rdata_nxt = {CFG_EN, CFG_MASTER, CFG_CPOL, ncpha_r,
                                      burst_len_r, burst_gap_r, 10'h000, CFG_CS_AUTO,
                                      CFG_SS, 2'h3, 1'b0, CFG_RATE, 1'b0};
            spi_tail_pkg::A_LG_IEN:  rdata_nxt = {7'h00, lien_r};
            default:                 rdata_nxt = 32'h00000000;
        endcase
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= 32'h00000000;
        end else begin
            RDATA <= RD ? rdata_nxt : 32'h00000000;
        end
    end

    property p_ovr_clr;
        @(posedge MCLK) disable iff (RST)
        (wr_iclr && WDATA[spi_tail_pkg::CLR_OVR] && !(RX_PUSH && rx_full)) |=> (rx_lvl == 5'h00) && !ovr_r;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun clear failed");
    property p_route;
        @(posedge MCLK) disable iff (RST)
        IRQ_AUX |-> $past(cpu_sel_r[1]) && $past(irq_any);
    endproperty
    a_route: assert property (p_route) else $error("aux irq without select");
    property p_tx_req;
        @(posedge MCLK) disable iff (RST)
        TX_DMA_SREQ |-> $past(dma_ctl_r[1]) && $past(en) && !$past(tx_full);
    endproperty
    a_tx_req: assert property (p_tx_req) else $error("tx request without cause");
    property p_tx_burst;
        @(posedge MCLK) disable iff (RST)
        (dma_ctl_r[1] && en && tx_lvl > 5'h0C) |=> !TX_DMA_BREQ;
    endproperty
    a_tx_burst: assert property (p_tx_burst) else $error("tx burst with little room");
    property p_rx_req;
        @(posedge MCLK) disable iff (RST)
        (dma_ctl_r[0] && en && !rx_empty) |=> RX_DMA_SREQ;
    endproperty
    a_rx_req: assert property (p_rx_req) else $error("rx request missing");
    property p_rx_burst;
        @(posedge MCLK) disable iff (RST)
        RX_DMA_BREQ |-> $past(rx_lvl) >= 5'h04;
    endproperty
    a_rx_burst: assert property (p_rx_burst) else $error("rx burst below four");
    property p_dma_off;
        @(posedge MCLK) disable iff (RST)
        !en |=> !TX_DMA_SREQ && !TX_DMA_BREQ && !RX_DMA_SREQ && !RX_DMA_BREQ;
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("request while disabled");
    property p_hv_zero;
        @(posedge MCLK) disable iff (RST)
        (RD && ADDR == spi_tail_pkg::A_LG_DATA) |=> !RDATA[17];
    endproperty
    a_hv_zero: assert property (p_hv_zero) else $error("high valid reads one");
    property p_lstat_cnt;
        @(posedge MCLK) disable iff (RST)
        (RD && ADDR == spi_tail_pkg::A_LG_STAT) |=> RDATA[17:9] == {4'h0, $past(tx_lvl)};
    endproperty
    a_lstat_cnt: assert property (p_lstat_cnt) else $error("bad out count");
    property p_phase;
        @(posedge MCLK) disable iff (RST)
        wr_lctrl |=> CFG_CPHA == !$past(WDATA[spi_tail_pkg::LC_NCPHA]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase not inverted");
    property p_soft;
        @(posedge MCLK) disable iff (RST)
        soft_clr |=> tx_lvl == 5'h00 && rx_lvl == 5'h00;
    endproperty
    a_soft: assert property (p_soft) else $error("soft clear left data");
    property p_irq_main;
        @(posedge MCLK) disable iff (RST)
        !$past(RST) |-> IRQ_MAIN == ($past(irq_any) && $past(cpu_sel_r[0]));
    endproperty
    a_irq_main: assert property (p_irq_main) else $error("main irq mismatch");
    c_burst: cover property (@(posedge MCLK) disable iff (RST) RX_DMA_BREQ);
    c_aux: cover property (@(posedge MCLK) disable iff (RST) IRQ_AUX && !IRQ_MAIN);
    c_ovr: cover property (@(posedge MCLK) disable iff (RST) RX_PUSH && rx_full);
endmodule // spi_irq_dma_legacy_regs

// file: spi_tail_pkg.sv
// constants for the serial controller interrupt, dma and legacy register tail
package spi_tail_pkg;
    // register byte addresses
    localparam logic [31:0] A_INT_CLR = 32'h101406A0;
    localparam logic [31:0] A_CPU_SEL = 32'h101406A4;
    localparam logic [31:0] A_DMA_CTL = 32'h101406A8;
    localparam logic [31:0] A_LG_DATA = 32'h101406B0;
    localparam logic [31:0] A_LG_STAT = 32'h101406B4;
    localparam logic [31:0] A_LG_CTRL = 32'h101406B8;
    localparam logic [31:0] A_LG_IEN  = 32'h101406BC;
    // reset values
    localparam logic [1:0]  CPU_SEL_RST = 2'h1;
    localparam logic [1:0]  DMA_CTL_RST = 2'h0;
    // fifo shape and fixed fill thresholds
    localparam int          DATA_W      = 8;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          FIFO_AW     = 4;
    localparam int          LVL_W       = 5;
    localparam logic [4:0]  FILL_FIX    = 5'h04;
    localparam logic [4:0]  TX_BURST_MAX = 5'h0C;
    // field positions
    localparam int CLR_OVR    = 0;
    localparam int CLR_TMO    = 1;
    localparam int SEL_MAIN   = 0;
    localparam int SEL_AUX    = 1;
    localparam int DMA_RX     = 0;
    localparam int DMA_TX     = 1;
    localparam int LD_VALID0  = 16;
    localparam int LS_SEL     = 25;
    localparam int LS_OEMPTY  = 23;
    localparam int LS_OLVL    = 21;
    localparam int LS_IFULL   = 20;
    localparam int LS_IDATA   = 19;
    localparam int LS_ILVL    = 18;
    localparam int LC_EN      = 31;
    localparam int LC_MS      = 30;
    localparam int LC_CPOL    = 29;
    localparam int LC_NCPHA   = 28;
    localparam int LC_OFLUSH  = 21;
    localparam int LC_IFLUSH  = 20;
    localparam int LC_CSAUTO  = 11;
    localparam int LC_SOFT    = 0;
endpackage

// file: tb_spi_irq_dma_legacy_regs.sv
// self-checking bench for the interrupt, dma and legacy register tail
`timescale 1ns/1ns
module tb_spi_irq_dma_legacy_regs;
    logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mod_en = 1'b0, rd_q = 1'b0;
    logic        sel_pin = 1'b0, tmo = 1'b0, drain = 1'b0, slow = 1'b0, go = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d;
    logic [6:0]  mask = 7'h00;
    logic [7:0]  n_push = 8'h00, tx_byte, got_byte, rx_byte;
    logic        tx_avail, tx_pop, rx_push, slv_send, got, irq_m, irq_a, tsr, tbr, rsr, rbr;
    logic        c_en, c_ms, c_pol, c_pha, c_cs;
    logic [2:0]  c_ss;
    logic [3:0]  c_rate;
    logic [63:0] e;
    logic [63:0] rq[$];
    logic [7:0]  txq[$];
    int          error_cnt = 0, comparisons = 0, seed = 30971, i, k;

    always #4 mclk = ~mclk;

    spi_irq_dma_legacy_regs dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MOD_EN(mod_en), .IRQ_MASK(mask), .SLAVE_SENDING(slv_send), .EXT_SEL_PIN(sel_pin),
        .RX_TMO(tmo), .RX_PUSH(rx_push), .RX_BYTE(rx_byte), .TX_POP(tx_pop), .TX_BYTE(tx_byte),
        .TX_AVAIL(tx_avail), .IRQ_MAIN(irq_m), .IRQ_AUX(irq_a), .TX_DMA_SREQ(tsr), .TX_DMA_BREQ(tbr),
        .RX_DMA_SREQ(rsr), .RX_DMA_BREQ(rbr), .CFG_EN(c_en), .CFG_MASTER(c_ms), .CFG_CPOL(c_pol),
        .CFG_CPHA(c_pha), .CFG_CS_AUTO(c_cs), .CFG_SS(c_ss), .CFG_RATE(c_rate));

    serial_engine_model far (.clk(mclk), .rst(rst), .go(go), .n_push(n_push), .drain(drain), .slow(slow),
        .tx_byte(tx_byte), .tx_avail(tx_avail), .tx_pop(tx_pop), .rx_push(rx_push), .rx_byte(rx_byte),
        .sending(slv_send), .got(got), .got_byte(got_byte));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr32(input logic [31:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // note the expected word and mask, then issue the read
    task automatic rd32(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m);
        rq.push_back({m, x});
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
    endtask

    task automatic feed(input int n);
        @(posedge mclk);
        n_push <= 8'(n);
        go     <= 1'b1;
        @(posedge mclk);
        go     <= 1'b0;
        tick(2 * n + 4);
    endtask

    // compare read data and drained bytes against the oldest notes
    always @(posedge mclk) begin
        if (rd_q) begin
            e = rq.pop_front();
            check(rdata & e[63:32], e[31:0]);
        end
        if (got)
            check(got_byte, txq.pop_front());
        rd_q <= rd;
    end

    // bound on the whole run
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        check(c_pha, 1'b1);
        rd32(spi_tail_pkg::A_CPU_SEL, 32'h1, '1);
        rd32(spi_tail_pkg::A_DMA_CTL, 32'h0, '1);
        rd32(spi_tail_pkg::A_LG_IEN, 32'h0, '1);
        rd32(spi_tail_pkg::A_LG_CTRL, 32'hC0, '1);
        wr32(32'h101406AC, '1);
        rd32(32'h101406AC, 32'h0, '1);
        rd32(spi_tail_pkg::A_CPU_SEL, 32'h1, '1);
        // every rate code with random neighbouring fields
        for (i = 0; i < 16; i++) begin
            d = ($random(seed) & 32'hFFC00F00) | (i << 1);
            wr32(spi_tail_pkg::A_LG_CTRL, d);
            tick(2);
            check({c_en, c_ms, c_pol, c_pha, c_cs, c_ss, c_rate}, {d[31:29], ~d[28], d[11:8], d[4:1]});
            rd32(spi_tail_pkg::A_LG_CTRL, d | 32'hC0, '1);
        end
        sel_pin <= 1'b1;
        wr32(spi_tail_pkg::A_LG_CTRL, 32'h0);
        tick(4);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h02000000, 32'h02000000);
        // transmit side: fill past full, dma levels at each step
        mod_en <= 1'b1;
        wr32(spi_tail_pkg::A_DMA_CTL, 32'h2);
        wr32(spi_tail_pkg::A_LG_DATA, 32'h55);
        for (i = 1; i <= 17; i++) begin
            d = ($random(seed) & 32'h0000FFFF) | 32'h00010000;
            wr32(spi_tail_pkg::A_LG_DATA, d);
            if (i <= 16)
                txq.push_back(d[7:0]);
            tick(2);
            check({tsr, tbr}, {i < 16, i < 13});
            if (i == 13) begin
                mod_en <= 1'b0;
                tick(2);
                check({tsr, tbr}, 2'b00);
                mod_en <= 1'b1;
                tick(2);
            end
        end
        rd32(spi_tail_pkg::A_LG_STAT, 32'h03002000, 32'h0323FE00);
        rd32(spi_tail_pkg::A_LG_DATA, 32'h0, 32'h00030000);
        slow  <= 1'b1;
        drain <= 1'b1;
        for (k = 0; k < 400 && txq.size() > 0; k++)
            tick(1);
        if (txq.size() > 0) begin
            error_cnt++;
            print_verdict();
        end
        drain <= 1'b0;
        tick(2);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h00A00000, 32'h00A3FE00);
        wr32(spi_tail_pkg::A_LG_STAT, 32'hFF7FFFFF);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h00A00000, 32'h00A3FE00);
        wr32(spi_tail_pkg::A_LG_STAT, 32'h00800000);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h00200000, 32'h00A3FE00);
        // receive side: dma levels, legacy full interrupt to both processors
        wr32(spi_tail_pkg::A_DMA_CTL, 32'h1);
        wr32(spi_tail_pkg::A_LG_IEN, 32'h00100000);
        wr32(spi_tail_pkg::A_CPU_SEL, 32'h3);
        feed(3);
        check({rsr, rbr, irq_m}, 3'b100);
        feed(13);
        check({rsr, rbr, irq_m, irq_a}, 4'hF);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h001C0010, 32'h001C01FF);
        rd32(spi_tail_pkg::A_LG_DATA, 32'h000100A0, 32'h0003FFFF);
        tick(3);
        check({irq_m, irq_a}, 2'b00);
        wr32(spi_tail_pkg::A_DMA_CTL, 32'h0);
        tick(2);
        check({rsr, rbr}, 2'b00);
        wr32(spi_tail_pkg::A_LG_CTRL, 32'h1);
        tick(2);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h0, 32'h001C01FF);
        // overrun and timeout events on the auxiliary route only
        wr32(spi_tail_pkg::A_LG_IEN, 32'h0);
        wr32(spi_tail_pkg::A_CPU_SEL, 32'h2);
        mask <= 7'h01;
        feed(17);
        check({irq_m, irq_a}, 2'b01);
        wr32(spi_tail_pkg::A_INT_CLR, 32'h1);
        tick(2);
        check(irq_a, 1'b0);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h0, 32'h000801FF);
        mask <= 7'h02;
        @(posedge mclk);
        tmo <= 1'b1;
        @(posedge mclk);
        tmo <= 1'b0;
        tick(2);
        check(irq_a, 1'b1);
        wr32(spi_tail_pkg::A_INT_CLR, 32'h2);
        tick(2);
        check(irq_a, 1'b0);
        // legacy flush bits empty both fifos, then primary tx empty source
        feed(3);
        wr32(spi_tail_pkg::A_LG_DATA, 32'h000100AA);
        wr32(spi_tail_pkg::A_LG_CTRL, 32'h00300000);
        tick(2);
        rd32(spi_tail_pkg::A_LG_STAT, 32'h00200000, 32'h01FFFFFF);
        mask <= 7'h40;
        tick(2);
        check(irq_a, 1'b1);
        tick(3);
        print_verdict();
    end
endmodule // tb_spi_irq_dma_legacy_regs
